// [rtl/legacy_decode_pkg.sv]
// Package: constants for the legacy address decoder
package legacy_decode_pkg;
   // ----------------------------------------------------------------------
   // Register map (word offsets are byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0]  SEG_ATTR_OFS       = 8'h00;
   localparam logic [7:0]  GFX_CTRL_OFS       = 8'h04;
   localparam logic [7:0]  DECODE_STATUS_OFS  = 8'h08;
   localparam logic [7:0]  LAST_ROUTE_OFS     = 8'h0C;
   // Control field positions in GFX_CTRL
   localparam int          PORT_ON_BIT        = 0;
   localparam int          MONO_FWD_BIT       = 1;
   localparam int          GMODE_LSB          = 2;
   localparam int          BRIDGE_CMD_MEM_BIT = 4;
   localparam int          BRIDGE_VGA_BIT     = 5;
   localparam int          GCMD_MEM_BIT       = 6;
   localparam int          VIDCTL_MONO_BIT    = 7;
   localparam int          MANAGEMENT_RAM_CONTROL_OPEN_BIT     = 8;
   localparam int          MANAGEMENT_RAM_CONTROL_EN_BIT       = 9;
   localparam logic [31:0] SEG_ATTR_RESET     = 32'h0000_0000;
   localparam logic [31:0] GFX_CTRL_RESET     = 32'h0000_0000;
   // ----------------------------------------------------------------------
   // Address ranges (bits 19:0 of a sub-1MB address)
   // ----------------------------------------------------------------------
   localparam logic [19:0] DOS_TOP            = 20'h9FFFF;
   localparam logic [19:0] VGA_BASE           = 20'hA0000;
   localparam logic [19:0] VGA_TOP            = 20'hBFFFF;
   localparam logic [19:0] MONO_BASE          = 20'hB0000;
   localparam logic [19:0] MONO_TOP           = 20'hB7FFF;
   localparam logic [19:0] SEG_BASE           = 20'hC0000;
   localparam logic [19:0] SYSBIOS_BASE       = 20'hF0000;
   localparam int          SEG_SHIFT          = 14;
   localparam int          NUM_SEGS           = 13;
   localparam int          ADDR_W             = 36;
   localparam int          IO_W               = 17;
   // Monochrome I/O ports
   localparam logic [16:0] MIO_0              = 17'h003B4;
   localparam logic [16:0] MIO_1              = 17'h003B5;
   localparam logic [16:0] MIO_2              = 17'h003B8;
   localparam logic [16:0] MIO_3              = 17'h003B9;
   localparam logic [16:0] MIO_4              = 17'h003BA;
   localparam logic [16:0] MIO_5              = 17'h003BF;
   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      TGT_NONE  = 3'h0,
      TGT_DRAM  = 3'h1,
      TGT_HUB   = 3'h3,
      TGT_GPORT = 3'h2,
      TGT_IGFX  = 3'h6,
      TGT_LOCAL = 3'h7
   } target_t;
   typedef enum logic [1:0] {
      SRC_HOST  = 2'h0,
      SRC_HUB   = 2'h1,
      SRC_GPORT = 2'h2
   } source_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACK  = 2'b01
   } bus_state_t;
endpackage : legacy_decode_pkg

// [rtl/legacy_address_decoder.sv]
// Address decode and steering for host, hub and graphics port cycles
// What this block does
// - Claim host memory accesses above 4 GB locally, never forwarding them.
// - Above 4 GB drop write data and return zero read data.
// - Decode a 64 GB memory space and a 64 KB plus three I/O space.
// - Legacy ranges go to the hub, except video which may use internal graphics.
// - 000000h to 09FFFFh always goes to main DRAM.
// - Video window ignores segment attributes; port switch picks mode or bridge steering.
// - Video steering applies equally to host, hub and graphics port cycles.
// - Hub to graphics port video cycles allow memory writes only.
// - Graphics port video accesses targeting this device end in master abort.
// - Internal graphics mode: video window is management RAM per its controls.
// - Port system with mono forward set sends B0000h-B7FFFh to hub.
// - Mono forward also sends I/O 3B4,3B5,3B8,3B9,3BA,3BF to hub.
// - Internal graphics: mono forwarding uses mode, graphics command and video bits.
// - C0000h-DFFFFh is eight 16 KB segments with four access states.
// - DRAM behind a disabled segment is not relocated anywhere.
// - E0000h-EFFFFh is four 16 KB segments with read and write attributes.
// - F0000h-FFFFFh segment resets read and write disabled, going to hub.
// - Thirteen segments from C0000h have own read and write enables.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module legacy_address_decoder
   import legacy_decode_pkg::*;
(
   // Clock and reset
   input  wire logic                             clk_i,
   input  wire logic                             rst_i,
   // Wishbone register slave
   input  wire logic                             wb_cyc_i,
   input  wire logic                             wb_stb_i,
   input  wire logic                             wb_we_i,
   input  wire logic [7:0]                       wb_adr_i,
   input  wire logic [3:0]                       wb_sel_i,
   input  wire logic [31:0]                      wb_dat_i,
   output logic      [31:0]                      wb_dat_o,
   output logic                                  wb_ack_o,
   // Cycle to decode
   input  wire logic                             req_valid_i,
   input  wire legacy_decode_pkg::source_t       req_src_i,
   input  wire logic                             req_io_i,
   input  wire logic                             req_write_i,
   input  wire logic                             req_smm_i,
   input  wire logic [legacy_decode_pkg::ADDR_W-1:0] req_addr_i,
   // Routing decision
   output logic                                  route_valid_o,
   output legacy_decode_pkg::target_t            route_target_o,
   output logic                                  route_zero_data_o,
   output logic                                  route_drop_write_o,
   output logic                                  route_master_abort_o
);
   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      bus_state_t  bus;
      logic [31:0] rdata;
      logic [25:0] seg_attr;
      logic [9:0]  gfx_ctrl;
      logic [15:0] hit_count;
      logic        route_valid;
      target_t     target;
      logic        zero_data;
      logic        drop_write;
      logic        master_abort;
   } state_t;

   state_t s_reg;
   state_t s_next;

   logic [19:0]          low_addr;
   logic                 above_4g;
   logic                 below_1m;
   logic [3:0]           seg_idx;
   logic                 seg_rd_en;
   logic                 seg_wr_en;
   logic                 port_on;
   logic                 mono_fwd;
   logic [1:0]           gmode;
   logic                 vga_to_gfx;
   logic                 mono_active;
   logic                 mono_io_hit;
   logic                 in_vga;
   logic                 in_mono;
   logic [12:0]          seg_rd_vec;
   logic [12:0]          seg_wr_vec;
   target_t              tgt;
   logic                 zero_d;
   logic                 drop_w;
   logic                 mabort;
   logic [IO_W-1:0]      io_addr;

   // ----------------------------------------------------------------------
   // Per-segment attributes: two bits each, bit0 read, bit1 write
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_SEGS; g++) begin : g_seg
         assign seg_rd_vec[g] = s_reg.seg_attr[2*g];
         assign seg_wr_vec[g] = s_reg.seg_attr[2*g+1];
      end
   endgenerate

   assign low_addr = req_addr_i[19:0];
   assign io_addr  = req_addr_i[IO_W-1:0];
   assign above_4g = |req_addr_i[ADDR_W-1:32];
   assign below_1m = ~|req_addr_i[31:20];
   assign port_on  = s_reg.gfx_ctrl[PORT_ON_BIT];
   assign mono_fwd = s_reg.gfx_ctrl[MONO_FWD_BIT];
   assign gmode    = s_reg.gfx_ctrl[GMODE_LSB +: 2];
   assign in_vga   = below_1m && low_addr >= VGA_BASE && low_addr <= VGA_TOP;
   assign in_mono  = below_1m && low_addr >= MONO_BASE && low_addr <= MONO_TOP;

   // Segment index: 0..7 expansion, 8..11 extended BIOS, 12 system BIOS
   always_comb begin
      if (low_addr >= SYSBIOS_BASE) begin
         seg_idx = 4'hC;
      end else begin
         seg_idx = {1'b0, 3'(low_addr[19:SEG_SHIFT] - SEG_BASE[19:SEG_SHIFT])};
         if (low_addr[19:SEG_SHIFT] >= 6'h38) begin
            seg_idx = 4'(low_addr[19:SEG_SHIFT] - SEG_BASE[19:SEG_SHIFT]);
         end
      end
   end
   assign seg_rd_en = seg_rd_vec[seg_idx];
   assign seg_wr_en = seg_wr_vec[seg_idx];

   // Video steering: port on uses bridge command and control, else mode select
   assign vga_to_gfx = port_on ?
      (s_reg.gfx_ctrl[BRIDGE_CMD_MEM_BIT] && s_reg.gfx_ctrl[BRIDGE_VGA_BIT]) :
      (gmode != 2'b00);
   // Mono forwarding: port system uses its enable; internal graphics needs all three
   assign mono_active = port_on ? mono_fwd :
      (mono_fwd && gmode != 2'b00 && s_reg.gfx_ctrl[GCMD_MEM_BIT]
       && s_reg.gfx_ctrl[VIDCTL_MONO_BIT]);
   assign mono_io_hit = io_addr == MIO_0 || io_addr == MIO_1 || io_addr == MIO_2
      || io_addr == MIO_3 || io_addr == MIO_4 || io_addr == MIO_5;

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   always_comb begin
      tgt    = TGT_HUB;
      zero_d = 1'b0;
      drop_w = 1'b0;
      mabort = 1'b0;
      if (req_io_i) begin
         tgt = (mono_active && mono_io_hit) ? TGT_HUB : (port_on ? TGT_GPORT : TGT_HUB);
         if (!port_on && !(mono_active && mono_io_hit) && gmode != 2'b00) begin
            tgt = TGT_IGFX;
         end
      end else if (above_4g) begin
         tgt    = TGT_LOCAL;
         zero_d = ~req_write_i;
         drop_w = req_write_i;
      end else if (!below_1m) begin
         tgt = TGT_HUB;
      end else if (low_addr <= DOS_TOP) begin
         tgt = TGT_DRAM;
      end else if (in_vga) begin
         // Same steering decision for every source; management RAM (host only) and aborts then depend on the source
         if (in_mono && mono_active) begin
            tgt = TGT_HUB;
         end else if (vga_to_gfx) begin
            tgt = port_on ? TGT_GPORT : TGT_IGFX;
         end else begin
            tgt = TGT_HUB;
         end
         if (!port_on && gmode != 2'b00 && s_reg.gfx_ctrl[MANAGEMENT_RAM_CONTROL_EN_BIT]
             && (req_smm_i || s_reg.gfx_ctrl[MANAGEMENT_RAM_CONTROL_OPEN_BIT]) && req_src_i == SRC_HOST) begin
            tgt = TGT_DRAM;
         end
         if (req_src_i == SRC_HUB && tgt == TGT_GPORT && !req_write_i) begin
            tgt    = TGT_NONE;
            mabort = 1'b1;
         end
         if (req_src_i == SRC_GPORT && tgt != TGT_HUB) begin
            tgt    = TGT_NONE;
            mabort = 1'b1;
         end
      end else begin
         // No remap of disabled segments: they simply go to the hub
         if (req_write_i) begin
            tgt = seg_wr_en ? TGT_DRAM : TGT_HUB;
         end else begin
            tgt = seg_rd_en ? TGT_DRAM : TGT_HUB;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Next state and register access
   // ----------------------------------------------------------------------
   always_comb begin
      s_next              = s_reg;
      s_next.route_valid  = req_valid_i;
      // Target holds between requests so the last route stays readable
      s_next.target       = req_valid_i ? tgt : s_reg.target;
      s_next.zero_data    = req_valid_i && zero_d;
      s_next.drop_write   = req_valid_i && drop_w;
      s_next.master_abort = req_valid_i && mabort;
      if (req_valid_i && tgt == TGT_LOCAL) begin
         s_next.hit_count = s_reg.hit_count + 16'h0001;
      end
      unique case (s_reg.bus)
         ST_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               s_next.bus   = ST_ACK;
               s_next.rdata = 32'h0000_0000;
               if (wb_we_i) begin
                  if (wb_adr_i == SEG_ATTR_OFS) begin
                     for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                           s_next.seg_attr = 26'(({6'h00, s_next.seg_attr}
                              & ~(32'h0000_00FF << (8 * b))) | (wb_dat_i & (32'h0000_00FF << (8 * b))));
                        end
                     end
                  end else if (wb_adr_i == GFX_CTRL_OFS) begin
                     if (wb_sel_i[0]) begin
                        s_next.gfx_ctrl[7:0] = wb_dat_i[7:0];
                     end
                     if (wb_sel_i[1]) begin
                        s_next.gfx_ctrl[9:8] = wb_dat_i[9:8];
                     end
                  end
               end else begin
                  unique case (wb_adr_i)
                     SEG_ATTR_OFS:      s_next.rdata = {6'h00, s_reg.seg_attr};
                     GFX_CTRL_OFS:      s_next.rdata = {22'h000000, s_reg.gfx_ctrl};
                     DECODE_STATUS_OFS: s_next.rdata = {16'h0000, s_reg.hit_count};
                     LAST_ROUTE_OFS:    s_next.rdata = {26'h0000000, s_reg.master_abort,
                                           s_reg.drop_write, s_reg.zero_data, s_reg.target};
                     default:           s_next.rdata = 32'h0000_0000;
                  endcase
               end
            end
         end
         ST_ACK: begin
            s_next.bus = ST_IDLE;
         end
         default: begin
            s_next.bus = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg.bus          <= ST_IDLE;
         s_reg.rdata        <= 32'h0000_0000;
         s_reg.seg_attr     <= SEG_ATTR_RESET[25:0];
         s_reg.gfx_ctrl     <= GFX_CTRL_RESET[9:0];
         s_reg.hit_count    <= 16'h0000;
         s_reg.route_valid  <= 1'b0;
         s_reg.target       <= TGT_NONE;
         s_reg.zero_data    <= 1'b0;
         s_reg.drop_write   <= 1'b0;
         s_reg.master_abort <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_ack_o             = s_reg.bus == ST_ACK;
   assign wb_dat_o             = s_reg.rdata;
   assign route_valid_o        = s_reg.route_valid;
   assign route_target_o       = s_reg.target;
   assign route_zero_data_o    = s_reg.zero_data;
   assign route_drop_write_o   = s_reg.drop_write;
   assign route_master_abort_o = s_reg.master_abort;
endmodule : legacy_address_decoder
`default_nettype wire

// [tb/legacy_decode_props.sv]
// Checker: routing and bus properties of the legacy address decoder
`timescale 1ns/1ps
`default_nettype none
module legacy_decode_props
   import legacy_decode_pkg::*;
(
   // Clock, reset and register bus
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic [7:0]             wb_adr_i,
   input wire logic [31:0]            wb_dat_i,
   input wire logic                   wb_ack_o,
   // Decode request and answer
   input wire logic                   req_valid_i,
   input wire legacy_decode_pkg::source_t req_src_i,
   input wire logic                   req_io_i,
   input wire logic                   req_write_i,
   input wire logic [legacy_decode_pkg::ADDR_W-1:0] req_addr_i,
   input wire legacy_decode_pkg::target_t route_target_o,
   input wire logic                   route_zero_data_o,
   input wire logic                   route_drop_write_o,
   input wire logic                   route_master_abort_o
);
   logic [25:0] seg_m;
   logic [9:0]  ctl_m;
   logic [3:0]  sidx;
   logic        mem, hi4, lo, vga, seg_go, mio;
   // Mirror of the attribute and control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seg_m <= SEG_ATTR_RESET[25:0];
         ctl_m <= GFX_CTRL_RESET[9:0];
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
         if (wb_adr_i == SEG_ATTR_OFS) seg_m <= wb_dat_i[25:0];
         if (wb_adr_i == GFX_CTRL_OFS) ctl_m <= wb_dat_i[9:0];
      end
   end
   always_comb begin
      mem    = req_valid_i && !req_io_i;
      hi4    = |req_addr_i[35:32];
      lo     = req_addr_i[35:20] == 16'h0000;
      vga    = lo && req_addr_i[19:17] == 3'h5;
      sidx   = (req_addr_i[17:14] > 4'hC) ? 4'hC : req_addr_i[17:14];
      seg_go = req_write_i ? seg_m[{sidx, 1'b1}] : seg_m[{sidx, 1'b0}];
      mio    = req_addr_i[16:0] inside {MIO_0, MIO_1, MIO_2, MIO_3, MIO_4, MIO_5};
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_pulse: assert property (s_take |=> s_pulse)
      else $error("register ack not a single pulse");
   a_high_claim: assert property (mem && hi4 |=> route_target_o == TGT_LOCAL)
      else $error("high access not claimed locally");
   a_high_data: assert property (mem && hi4 |=> route_zero_data_o != $past(req_write_i)
      && route_drop_write_o == $past(req_write_i)) else $error("high access data handling wrong");
   a_dos_dram: assert property (mem && lo && req_addr_i[19:0] <= DOS_TOP |=> route_target_o == TGT_DRAM)
      else $error("low area not sent to DRAM");
   a_seg_steer: assert property (mem && lo && req_addr_i[19:18] == 2'h3 && req_src_i == SRC_HOST
      |=> route_target_o == ($past(seg_go) ? TGT_DRAM : TGT_HUB)) else $error("segment steering wrong");
   a_video_port: assert property (mem && vga && req_src_i == SRC_HOST && ctl_m[1:0] == 2'h1
      |=> route_target_o == (ctl_m[5:4] == 2'h3 ? TGT_GPORT : TGT_HUB)) else $error("video steering wrong");
   a_mono_io: assert property (req_valid_i && req_io_i && ctl_m[1:0] == 2'h3 && mio
      |=> route_target_o == TGT_HUB) else $error("mono port not sent to hub");
   a_gport_abort: assert property (mem && vga && req_src_i == SRC_GPORT && ctl_m[1:0] == 2'h0
      && ctl_m[3:2] != 2'h0 |=> route_master_abort_o) else $error("port video access not aborted");
endmodule : legacy_decode_props
bind legacy_address_decoder legacy_decode_props legacy_decode_props_inst (.*);
`default_nettype wire

// [tb/cycle_source_model.sv]
// Model of the bus masters that present cycles to the decoder
`timescale 1ns/1ps
`default_nettype none
module cycle_source_model
   import legacy_decode_pkg::*;
(
   input  wire logic                  clk_i,
   output logic                       req_valid_o,
   output legacy_decode_pkg::source_t req_src_o,
   output logic                       req_io_o,
   output logic                       req_write_o,
   output logic                       req_smm_o,
   output logic [legacy_decode_pkg::ADDR_W-1:0] req_addr_o
);
   initial begin
      req_valid_o = 1'b0;
      req_src_o   = SRC_HOST;
      {req_io_o, req_write_o, req_smm_o, req_addr_o} = '0;
   end
   // One cycle per request; released lines are scrambled
   task automatic issue(input source_t s, input logic io, input logic wr, input logic smm,
                        input logic [ADDR_W-1:0] a);
      @(posedge clk_i);
      req_valid_o <= 1'b1;
      req_src_o   <= s;
      {req_io_o, req_write_o, req_smm_o, req_addr_o} <= {io, wr, smm, a};
      @(posedge clk_i);
      req_valid_o <= 1'b0;
      req_src_o   <= source_t'(~s);
      {req_io_o, req_write_o, req_smm_o, req_addr_o} <= ~{io, wr, smm, a};
   endtask : issue
endmodule : cycle_source_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench for the legacy address decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import legacy_decode_pkg::*;
   localparam logic [5:0] E_DRAM = {3'h0, TGT_DRAM}, E_HUB = {3'h0, TGT_HUB}, E_GP = {3'h0, TGT_GPORT};
   localparam logic [5:0] E_IG = {3'h0, TGT_IGFX}, E_RD4 = {3'h1, TGT_LOCAL}, E_WR4 = {3'h2, TGT_LOCAL};
   localparam logic [5:0] E_AB = 6'h20;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seg;
   logic        wb_ack_o, req_valid_i, req_io_i, req_write_i, req_smm_i, route_valid_o;
   logic        route_zero_data_o, route_drop_write_o, route_master_abort_o;
   source_t     req_src_i;
   target_t     route_target_o;
   logic [ADDR_W-1:0] req_addr_i, a;
   logic [16:0] mio[6] = '{MIO_0, MIO_1, MIO_2, MIO_3, MIO_4, MIO_5};
   logic [5:0]  rexp[$];
   logic [31:0] dexp[$];
   int          miscompares = 0, n_checks = 0;
   always #20 clk_i = ~clk_i;
   legacy_address_decoder legacy_address_decoder_inst (.*);
   cycle_source_model cycle_source_model_inst (.clk_i(clk_i), .req_valid_o(req_valid_i), .req_src_o(req_src_i),
      .req_io_o(req_io_i), .req_write_o(req_write_i), .req_smm_o(req_smm_i), .req_addr_o(req_addr_i));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, ad, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && n++ < 50);
      if (n > 50) miscompares++;
      {wb_cyc_i, wb_stb_i, wb_dat_i} <= {2'h0, ~d};
   endtask : wb
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      dexp.push_back(e);
      wb(1'b0, ad, 32'h0);
   endtask : rd
   task automatic cyc(input source_t s, input logic io, wr, smm, input logic [35:0] ad, input logic [5:0] e);
      rexp.push_back(e);
      cycle_source_model_inst.issue(s, io, wr, smm, ad);
   endtask : cyc
   // ----------------------------------------------------------------
   // Result watcher
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin : watch
      logic [5:0] e;
      if (route_valid_o === 1'b1) begin
         e = rexp.pop_front();
         check("route", e[5] ? {26'h0, route_master_abort_o, 5'h0} : {26'h0, route_master_abort_o,
            route_drop_write_o, route_zero_data_o, route_target_o}, {26'h0, e});
      end
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check("reg read", wb_dat_o, dexp.pop_front());
   end
   initial begin : watchdog
      #200000;
      miscompares++;
      complete_run();
   end
   initial begin
      void'($urandom(67));
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(SEG_ATTR_OFS, SEG_ATTR_RESET);
      rd(GFX_CTRL_OFS, GFX_CTRL_RESET);
      wb(1'b1, 8'h40, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0);
      cyc(SRC_HOST, 1'b0, 1'b0, 1'b0, 36'hF8000, E_HUB);
      cyc(SRC_HOST, 1'b0, 1'b1, 1'b0, 36'hFFFFF, E_HUB);
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 36'h1_0000_0000 : {4'($urandom_range(15, 1)), 32'($urandom)};
         cyc(source_t'(i % 3), 1'b0, i[0], 1'b0, a, i[0] ? E_WR4 : E_RD4);
      end
      wb(1'b1, DECODE_STATUS_OFS, 32'h0);
      rd(DECODE_STATUS_OFS, 32'h6);
      for (int k = 0; k < 3; k++) begin
         seg = (k == 0) ? 32'h03FF_FFFF : ($urandom & 32'h03FF_FFFF);
         wb(1'b1, SEG_ATTR_OFS, seg);
         rd(SEG_ATTR_OFS, seg);
         for (int n = 0; n < 13; n++) begin
            a = 36'hC0000 + 36'(n) * 36'h4000 + 36'($urandom_range(n == 12 ? 16'hFFFF : 16'h3FFF));
            cyc(SRC_HOST, 1'b0, 1'b0, 1'b0, a, seg[2*n] ? E_DRAM : E_HUB);
            cyc(SRC_HOST, 1'b0, 1'b1, 1'b0, a, seg[2*n+1] ? E_DRAM : E_HUB);
         end
      end
      wb(1'b1, GFX_CTRL_OFS, $urandom & 32'h3FF);
      for (int i = 0; i < 4; i++)
         cyc(source_t'(i % 3), 1'b0, i[0], i[1], 36'($urandom_range(20'h9FFFF)), E_DRAM);
      wb(1'b1, GFX_CTRL_OFS, 32'h31);
      cyc(SRC_HOST, 1'b0, 1'b0, 1'b0, 36'hA0000, E_GP);
      cyc(SRC_HUB, 1'b0, 1'b1, 1'b0, 36'hBFFFF, E_GP);
      cyc(SRC_HUB, 1'b0, 1'b0, 1'b0, 36'hA8000, E_AB);
      wb(1'b1, GFX_CTRL_OFS, 32'h33);
      cyc(SRC_HOST, 1'b0, 1'b0, 1'b0, 36'hB4000, E_HUB);
      cyc(SRC_HOST, 1'b0, 1'b0, 1'b0, 36'hB8000, E_GP);
      for (int i = 0; i < 6; i++) cyc(SRC_HOST, 1'b1, i[0], 1'b0, 36'(mio[i]), E_HUB);
      wb(1'b1, GFX_CTRL_OFS, 32'h11);
      cyc(SRC_HOST, 1'b0, 1'b1, 1'b0, 36'hA0000, E_HUB);
      wb(1'b1, GFX_CTRL_OFS, 32'h04);
      cyc(SRC_HOST, 1'b0, 1'b0, 1'b0, 36'hB0000, E_IG);
      cyc(SRC_HUB, 1'b0, 1'b1, 1'b0, 36'hA1000, E_IG);
      cyc(SRC_GPORT, 1'b0, 1'b0, 1'b0, 36'hA2000, E_AB);
      cyc(SRC_HOST, 1'b0, 1'b0, 1'b1, 36'hA0000, E_IG);
      wb(1'b1, GFX_CTRL_OFS, 32'h204);
      cyc(SRC_HOST, 1'b0, 1'b0, 1'b1, 36'hA0000, E_DRAM);
      cyc(SRC_HOST, 1'b0, 1'b0, 1'b0, 36'hA0000, E_IG);
      wb(1'b1, GFX_CTRL_OFS, 32'h0);
      cyc(SRC_HOST, 1'b0, 1'b0, 1'b0, 36'hAFFFF, E_HUB);
      rd(LAST_ROUTE_OFS, 32'h3);
      repeat (3) @(posedge clk_i);
      check("queues left", rexp.size() + dexp.size(), 32'h0);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
